/* io_port_watchdog_timer.sv */
`timescale 1ns/1ps
module io_port_watchdog_timer
	import wdt_pkg::*;
#(
	parameter int unsigned TICK_DIV = 32'(TICK_CYCLES),
	parameter int unsigned RST_CYCLES = RESET_PULSE_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [15:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [wdt_pkg::DATA_W-1:0] i_io_wdata,
	input wire wdt_pkg::action_t i_action,
	output logic [wdt_pkg::DATA_W-1:0] o_io_rdata,
	output logic o_running,
	output logic [wdt_pkg::INTERVAL_W-1:0] o_remaining,
	output logic o_cpu_rst_n,
	output logic o_irq
);
	import wdt_pkg::*;

	initial begin
		if (RST_CYCLES < 1 || RST_CYCLES > 255) $error("reset pulse length out of range");
		if (TICK_DIV < 2) $error("second tick divider out of range");
	end

	// ------------------------------------------------------------
	// port decode
	// ------------------------------------------------------------
	// one address compare shared by both strobes
	function automatic logic port_hit(input logic [15:0] addr);
		port_hit = (addr == WDT_PORT_ADDR);
	endfunction : port_hit

	function automatic logic [INTERVAL_W-1:0] interval_of(input logic [DATA_W-1:0] data);
		interval_of = data[INTERVAL_W-1:0];
	endfunction : interval_of

	logic hit_wr, hit_rd, tick;
	logic [INTERVAL_W-1:0] wr_interval;
	assign hit_wr = i_io_wr && port_hit(i_io_addr);
	assign hit_rd = i_io_rd && port_hit(i_io_addr);
	assign wr_interval = interval_of(i_io_wdata);

	wdt_tick_div #(
		.TICK_DIV(TICK_DIV)
	) u_tick (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_restart(hit_wr),
		.o_tick(tick)
	);

	// ------------------------------------------------------------
	// strap synchroniser
	// ------------------------------------------------------------
	// the action strap is a board pin, retimed before use
	localparam int SYNC_STAGES = 2;
	logic [SYNC_STAGES-1:0] act_sync_r, act_sync_nxt;
	logic act_irq;
	always_comb begin
		act_sync_nxt = {act_sync_r[SYNC_STAGES-2:0], (i_action == ACT_IRQ)};
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			act_sync_r <= '0;
		end else begin
			act_sync_r <= act_sync_nxt;
		end
	end
	assign act_irq = act_sync_r[SYNC_STAGES-1];

	// ------------------------------------------------------------
	// countdown
	// ------------------------------------------------------------
	wdt_state_t state_r, state_nxt;
	logic [INTERVAL_W-1:0] cnt_r, cnt_nxt;
	logic [7:0] pulse_r, pulse_nxt;
	logic cpu_rst_n_r, cpu_rst_n_nxt;
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		pulse_nxt = pulse_r;
		cpu_rst_n_nxt = cpu_rst_n_r;
		unique case (state_r)
			ST_OFF: begin
				cpu_rst_n_nxt = 1'b1;
			end
			ST_RUN: begin
				if (tick) begin
					if (cnt_r == INTERVAL_MIN) begin
						cnt_nxt = '0;
						state_nxt = ST_FIRE;
						pulse_nxt = 8'(RST_CYCLES);
						if (!act_irq) begin
							cpu_rst_n_nxt = 1'b0;
						end
					end else begin
						cnt_nxt = cnt_r - 1'b1;
					end
				end
			end
			ST_FIRE: begin
				if (pulse_r != 8'h00) begin
					pulse_nxt = pulse_r - 8'h01;
				end else begin
					cpu_rst_n_nxt = 1'b1;
					state_nxt = ST_OFF;
				end
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
		if (hit_wr) begin
			cnt_nxt = wr_interval;
			if (wr_interval == '0) begin
				state_nxt = ST_OFF;
			end else begin
				state_nxt = ST_RUN;
			end
		end else if (hit_rd) begin
			cnt_nxt = '0;
			state_nxt = ST_OFF;
		end
		// an access during the pulse ends it
		if ((hit_wr || hit_rd) && state_r == ST_FIRE) begin
			cpu_rst_n_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= ST_OFF;
			cnt_r <= INTERVAL_RESET;
			pulse_r <= 8'h00;
			cpu_rst_n_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			pulse_r <= pulse_nxt;
			cpu_rst_n_r <= cpu_rst_n_nxt;
		end
	end

	// ------------------------------------------------------------
	// expiry interrupt
	// ------------------------------------------------------------
	logic expire;
	assign expire = (state_r == ST_RUN) && tick && (cnt_r == INTERVAL_MIN);
	logic irq_r, irq_nxt;
	// a refresh in the expiry cycle wins over o_irq and the timer reloads, but o_cpu_rst_n still falls when act_irq is low
	always_comb begin
		irq_nxt = irq_r;
		if (expire && act_irq) begin
			irq_nxt = 1'b1;
		end
		if (hit_wr || hit_rd) begin
			irq_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	always_comb begin
		rdata_nxt = rdata_r;
		if (hit_rd) begin
			rdata_nxt = READ_VALUE;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_r <= READ_VALUE;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// every output straight from a register
	logic running_r, running_nxt;
	always_comb begin
		running_nxt = (state_nxt == ST_RUN);
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			running_r <= 1'b0;
		end else begin
			running_r <= running_nxt;
		end
	end

	assign o_io_rdata = rdata_r;
	assign o_running = running_r;
	assign o_remaining = cnt_r;
	assign o_cpu_rst_n = cpu_rst_n_r;
	assign o_irq = irq_r;
endmodule : io_port_watchdog_timer

/* wdt_pkg.sv */
package wdt_pkg;
	// ------------------------------------------------------------
	// port map
	// ------------------------------------------------------------
	localparam logic [15:0] WDT_PORT_ADDR = 16'h0443;
	localparam int DATA_W = 8;
	localparam int INTERVAL_W = 6;
	localparam logic [INTERVAL_W-1:0] INTERVAL_MIN = 6'h01;
	localparam logic [INTERVAL_W-1:0] INTERVAL_MAX = 6'h3f;
	localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 6'h00;
	localparam logic [DATA_W-1:0] READ_VALUE = 8'h00;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam longint CLK_HZ = 20000000;
	localparam longint TICK_MS = 1000;
	localparam longint TICK_CYCLES = (CLK_HZ * TICK_MS) / 1000;
	localparam int RESET_PULSE_CYCLES = 16;
	// ------------------------------------------------------------
	// expiry action and countdown states
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		ACT_RESET = 1'b0,
		ACT_IRQ = 1'b1
	} action_t;
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01,
		ST_FIRE = 2'b10
	} wdt_state_t;
endpackage : wdt_pkg

/* wdt_tick_div.sv */
`timescale 1ns/1ps
module wdt_tick_div #(
	parameter int unsigned TICK_DIV = 20000000
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_restart,
	output logic o_tick
);
	initial begin
		if (TICK_DIV < 2) $error("tick divider too small");
	end
	localparam int CW = $clog2(TICK_DIV);
	localparam logic [CW-1:0] LAST = CW'(TICK_DIV - 1);
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic tick_r, tick_nxt;
	always_comb begin
		cnt_nxt = cnt_r + 1'b1;
		tick_nxt = 1'b0;
		if (i_restart) begin
			cnt_nxt = '0;
		end else if (cnt_r == LAST) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign o_tick = tick_r;
endmodule : wdt_tick_div

/* io_port_watchdog_timer_checker.sv */
`timescale 1ns/1ps
module io_port_watchdog_timer_checker #(
	parameter int unsigned TICK_DIV = 8,
	parameter int unsigned RST_CYCLES = 4
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [15:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	input wire logic o_running,
	input wire logic [5:0] o_remaining,
	input wire logic o_cpu_rst_n,
	input wire logic o_irq
);
	wire logic hit = i_io_addr == 16'h0443;
	wire logic acc = hit && (i_io_wr || i_io_rd);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	chk_write_load: assert property (i_io_wr && hit && i_io_wdata[5:0] != 6'h00
		|=> o_running && o_remaining == $past(i_io_wdata[5:0])) else $error("load");
	chk_read_stop: assert property (i_io_rd && !i_io_wr && hit
		|=> !o_running && !o_irq && o_remaining == 6'h00) else $error("read stop");
	chk_zero_off: assert property (i_io_wr && hit && i_io_wdata[5:0] == 6'h00 |=> !o_running) else $error("zero");
	chk_stays_off: assert property (!o_running && !(i_io_wr && hit) |=> !o_running) else $error("off");
	chk_tick_step: assert property (o_running && $changed(o_remaining) && !$past(acc)
		|-> o_remaining == $past(o_remaining) - 6'h01) else $error("step");
	chk_expiry_act: assert property ($fell(o_running) && !$past(acc) |-> !o_cpu_rst_n || o_irq) else $error("act");
	chk_pulse_len: assert property ($fell(o_cpu_rst_n) |-> !o_cpu_rst_n [*5] ##1 o_cpu_rst_n) else $error("pulse");
endmodule : io_port_watchdog_timer_checker
bind io_port_watchdog_timer io_port_watchdog_timer_checker #(.TICK_DIV(TICK_DIV), .RST_CYCLES(RST_CYCLES)) chk (.*);

/* io_port_watchdog_timer_tb_top.sv */
`timescale 1ns/1ps
module io_port_watchdog_timer_tb_top;
	import wdt_pkg::*;
	logic i_mclk = 0, i_rstn = 0, i_io_wr = 0, i_io_rd = 0;
	logic [15:0] i_io_addr = 16'h0000;
	logic [7:0] i_io_wdata = 8'h00;
	action_t i_action = ACT_RESET;
	logic [7:0] o_io_rdata;
	logic o_running, o_cpu_rst_n, o_irq;
	logic [5:0] o_remaining;
	int failures = 0, samples_checked = 0, cyc = 0, i;
	io_port_watchdog_timer #(.TICK_DIV(8), .RST_CYCLES(4)) uut (.*);
	always #25 i_mclk = ~i_mclk;
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task automatic io(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(negedge i_mclk);
		i_io_addr = a;
		i_io_wdata = d;
		i_io_wr = w;
		i_io_rd = !w;
		@(negedge i_mclk);
		i_io_wr = 0;
		i_io_rd = 0;
	endtask : io
	task automatic wrap_up;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(negedge i_mclk);
		i_rstn = 1;
		cmp("st", 8'h00, {o_running, o_irq, o_remaining});
		io(16'h0443, 8'hc3, 1);
		cmp("st", 8'h83, {o_running, o_irq, o_remaining});
		repeat (12) @(negedge i_mclk);
		cmp("st", 8'h82, {o_running, o_irq, o_remaining});
		io(16'h0443, 8'h3f, 1);
		cmp("st", 8'hbf, {o_running, o_irq, o_remaining});
		io(16'h0443, 8'h00, 0);
		cmp("st", 8'h00, {o_running, o_irq, o_remaining});
		cmp("rdata", 8'h00, o_io_rdata);
		io(16'h0442, 8'h05, 1);
		cmp("st", 8'h00, {o_running, o_irq, o_remaining});
		for (i = 0; i < 2; i++) begin
			i_action = action_t'(i);
			io(16'h0443, 8'(i + 1), 1);
			repeat (8 * (i + 1) + 4) @(negedge i_mclk);
			cmp("act", 8'(3 * i), {6'h00, o_irq, o_cpu_rst_n});
			repeat (8) @(negedge i_mclk);
		end
		io(16'h0443, 8'h01, 1);
		io(16'h0443, 8'h40, 1);
		cmp("st", 8'h00, {o_running, o_irq, o_remaining});
		wrap_up();
	end
endmodule : io_port_watchdog_timer_tb_top
